//--- rtl/tcr_button_latch.sv
// sticky latched-touch flags for the buttons
module tcr_button_latch #(
  parameter int NUM_BUTTONS = 10
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   en_i,
  input  wire logic [NUM_BUTTONS-1:0] button_on_flag_i,
  input  wire logic [NUM_BUTTONS-1:0] clear_i,
  output logic      [NUM_BUTTONS-1:0] latched_o
);
  typedef struct packed {
    logic [NUM_BUTTONS-1:0] latched;
  } tcr_latch_state_t;

  tcr_latch_state_t state;
  tcr_latch_state_t next_state;

  // a touch seen in the clearing cycle survives: set wins
  always_comb begin
    next_state = state;
    next_state.latched = (state.latched & ~clear_i) | button_on_flag_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else if (en_i) begin
      state <= next_state;
    end
  end

  assign latched_o = state.latched;

  a_latch_sets : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && |button_on_flag_i |=> (latched_o & $past(button_on_flag_i)) == $past(button_on_flag_i))
    else $error("touched button not latched");
endmodule

//--- rtl/tcr_pkg.sv
// constants for the touch controller operating register bank
package tcr_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_MODE_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_HOST_OUTPUTS  = 8'h01;
  localparam logic [7:0] ADDR_CONFIG_SOURCE = 8'h03;
  localparam logic [7:0] ADDR_BUTTON_LOW    = 8'h04;
  localparam logic [7:0] ADDR_BUTTON_HIGH   = 8'h05;
  localparam logic [7:0] ADDR_LATCHED_LOW   = 8'h07;
  localparam logic [7:0] ADDR_LATCHED_HIGH  = 8'h08;
  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int DEEP_SLEEP_BIT   = 4;
  localparam int SOFT_RESET_BIT   = 3;
  localparam int MODE_MSB         = 2;
  localparam int OUTPUTS_LSB      = 4;
  localparam int FACTORY_BIT      = 6;
  localparam int NUM_OUTPUTS      = 4;
  localparam int NUM_BUTTONS      = 10;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] RESERVED_READ = 8'h00;
  localparam logic [2:0] MODE_LAST_VALID = 3'h4;
  localparam int SOFT_RESET_PULSE_CYCLES = 1;
  typedef enum logic [2:0] {
    TCR_MODE_OPERATING,
    TCR_MODE_LED_CONFIG,
    TCR_MODE_DEVICE_CONFIG,
    TCR_MODE_LINE_TEST,
    TCR_MODE_DEBUG_DATA
  } tcr_mode_t;
endpackage

//--- rtl/tcr_regs.sv
// operating-mode register bank of the ten-button touch controller
// ************************************************************
// register bank
// ************************************************************
// Overview of operation
// - every register starts at its power-on value and obeys its read/write access.
// - reserved offsets hold nothing defined and read back as zero here.
// - bit 4 of the mode register requests deep sleep and clears itself when sleep ends.
// - writing 1 to bit 3 of the mode register resets the controller, 0 does nothing.
// - bits 2:0 of the mode register select one of five device modes.
// - bits 7:4 of the output register drive host outputs 3 to 0 at their levels.
// - status bit 6 reads 1 when factory defaults were loaded, else 0.
// - offsets 04h and 05h show the live on/off state of buttons 7..0 and 9..8.
// - offsets 07h and 08h show latched touches of buttons 7..0 and 9..8.
module tcr_regs #(
  parameter int NUM_BUTTONS = tcr_pkg::NUM_BUTTONS
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   en_i,
  input  wire logic [7:0]             addr_i,
  input  wire logic                   wr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  input  wire logic                   factory_loaded_i,
  input  wire logic                   deep_sleep_exit_i,
  input  wire logic [NUM_BUTTONS-1:0] button_on_flag_i,
  output logic                        deep_sleep_req_o,
  output logic                        soft_reset_o,
  output logic      [2:0]             device_mode_o,
  output logic      [3:0]             host_driven_output_o
);
  typedef struct packed {
    logic       deep_sleep;
    logic       soft_reset;
    logic [2:0] mode;
    logic [3:0] outputs;
    logic       factory;
    logic [7:0] rdata;
  } tcr_state_t;

  tcr_state_t             state;
  tcr_state_t             next_state;
  logic [NUM_BUTTONS-1:0] latched;
  logic [NUM_BUTTONS-1:0] latch_clear;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // ************************************************************
  // latched touch flags, cleared by reading them
  // ************************************************************
  always_comb begin
    latch_clear = '0;
    if (rd_i && hit(addr_i, tcr_pkg::ADDR_LATCHED_LOW)) begin
      latch_clear[7:0] = '1;
    end
    if (rd_i && hit(addr_i, tcr_pkg::ADDR_LATCHED_HIGH)) begin
      latch_clear[NUM_BUTTONS-1:8] = '1;
    end
  end

  tcr_button_latch #(
    .NUM_BUTTONS (NUM_BUTTONS)
  ) u_latch (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .en_i             (en_i),
    .button_on_flag_i (button_on_flag_i),
    .clear_i          (latch_clear),
    .latched_o        (latched)
  );

  // ************************************************************
  // write and read decode
  // ************************************************************
  always_comb begin
    next_state = state;
    next_state.soft_reset = 1'b0;
    next_state.factory = factory_loaded_i;
    // self-clear on sleep exit loses to a new request in the same cycle
    if (deep_sleep_exit_i) begin
      next_state.deep_sleep = 1'b0;
    end
    if (wr_i && hit(addr_i, tcr_pkg::ADDR_MODE_CONTROL)) begin
      next_state.deep_sleep = wdata_i[tcr_pkg::DEEP_SLEEP_BIT] |
                              (state.deep_sleep & ~deep_sleep_exit_i);
      next_state.soft_reset = wdata_i[tcr_pkg::SOFT_RESET_BIT];
      if (wdata_i[tcr_pkg::MODE_MSB:0] <= tcr_pkg::MODE_LAST_VALID) begin
        next_state.mode = wdata_i[tcr_pkg::MODE_MSB:0];
      end
    end
    if (wr_i && hit(addr_i, tcr_pkg::ADDR_HOST_OUTPUTS)) begin
      next_state.outputs = wdata_i[7:tcr_pkg::OUTPUTS_LSB];
    end
    next_state.rdata = tcr_pkg::RESERVED_READ;
    if (rd_i) begin
      case (addr_i)
        tcr_pkg::ADDR_MODE_CONTROL: begin
          next_state.rdata = {3'h0, state.deep_sleep, 1'b0, state.mode};
        end
        tcr_pkg::ADDR_HOST_OUTPUTS: begin
          next_state.rdata = {state.outputs, 4'h0};
        end
        tcr_pkg::ADDR_CONFIG_SOURCE: begin
          next_state.rdata = 8'h00;
          next_state.rdata[tcr_pkg::FACTORY_BIT] = state.factory;
        end
        tcr_pkg::ADDR_BUTTON_LOW: begin
          next_state.rdata = button_on_flag_i[7:0];
        end
        tcr_pkg::ADDR_BUTTON_HIGH: begin
          next_state.rdata = {6'h00, button_on_flag_i[9:8]};
        end
        tcr_pkg::ADDR_LATCHED_LOW: begin
          next_state.rdata = latched[7:0];
        end
        tcr_pkg::ADDR_LATCHED_HIGH: begin
          next_state.rdata = {6'h00, latched[9:8]};
        end
        default: begin
          next_state.rdata = tcr_pkg::RESERVED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else if (en_i) begin
      state <= next_state;
    end
  end

  assign rdata_o              = state.rdata;
  assign deep_sleep_req_o     = state.deep_sleep;
  assign soft_reset_o         = state.soft_reset;
  assign device_mode_o        = state.mode;
  assign host_driven_output_o = state.outputs;

  // ************************************************************
  // checks
  // ************************************************************
  a_mode_valid_write : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && wr_i && addr_i == 8'h00 && wdata_i[2:0] <= 3'h4 |=> device_mode_o == $past(wdata_i[2:0]))
    else $error("valid mode write not taken");
  a_mode_bad_code : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && wr_i && addr_i == 8'h00 && wdata_i[2:0] > 3'h4 |=> $stable(device_mode_o))
    else $error("invalid mode code changed mode");
  a_soft_reset_pulse : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    soft_reset_o |-> $past(wr_i && addr_i == 8'h00 && wdata_i[3]) ##1 (!soft_reset_o || $past(wr_i)))
    else $error("soft reset without a write of one");
  a_sleep_clears : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && deep_sleep_exit_i && !(wr_i && addr_i == 8'h00) |=> !deep_sleep_req_o)
    else $error("deep sleep bit not cleared on exit");
  a_outputs_write : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && wr_i && addr_i == 8'h01 |=> host_driven_output_o == $past(wdata_i[7:4]))
    else $error("host outputs not updated");
  a_outputs_hold : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_i && addr_i == 8'h01) |=> $stable(host_driven_output_o))
    else $error("host outputs changed without a write");
  a_button_read : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rd_i && addr_i == 8'h04 |=> rdata_o == $past(button_on_flag_i[7:0]))
    else $error("button state read wrong");
  a_factory_read : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(en_i && rst_n_i) && en_i && rd_i && addr_i == 8'h03 |=>
      rdata_o[6] == $past(factory_loaded_i, 2))
    else $error("factory bit read wrong");
  a_reserved_zero : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rd_i && addr_i == 8'h02 |=> rdata_o == 8'h00)
    else $error("reserved offset not zero");
  a_reset_values : assert property (@(posedge clk_i)
    !rst_n_i |=> device_mode_o == 3'h0 && host_driven_output_o == 4'h0 && !deep_sleep_req_o)
    else $error("reset values wrong");
  // read data lasts one cycle so a stale byte is never taken for a fresh read
  a_rdata_idle : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data not cleared after read");
  a_freeze_hold : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !en_i |=> $stable(rdata_o) && $stable(device_mode_o) && $stable(host_driven_output_o) &&
      $stable(deep_sleep_req_o) && $stable(soft_reset_o))
    else $error("state moved while clock enable low");
  a_sleep_request : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && wr_i && addr_i == 8'h00 && wdata_i[4] |=> deep_sleep_req_o)
    else $error("deep sleep request not taken");
  a_sleep_write_wins : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && deep_sleep_exit_i && wr_i && addr_i == 8'h00 && wdata_i[4] |=> deep_sleep_req_o)
    else $error("deep sleep write lost to exit pulse");
  a_soft_reset_zero : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && wr_i && addr_i == 8'h00 && !wdata_i[3] |=> !soft_reset_o)
    else $error("soft reset from a write of zero");
  a_mode_readback : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rd_i && addr_i == 8'h00 |=> rdata_o[7:5] == 3'h0 && !rdata_o[3] &&
      rdata_o[2:0] == $past(device_mode_o))
    else $error("mode register read wrong");
  a_outputs_readback : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rd_i && addr_i == 8'h01 |=> rdata_o == {$past(host_driven_output_o), 4'h0})
    else $error("output register read wrong");
  a_button_high : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rd_i && addr_i == 8'h05 |=> rdata_o == {6'h00, $past(button_on_flag_i[9:8])})
    else $error("upper button state read wrong");
  // reading clears the latched flags, unless a touch lands in the same cycle
  a_latch_low_clears : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rd_i && addr_i == 8'h07 && button_on_flag_i[7:0] == 8'h00 |=> latched[7:0] == 8'h00)
    else $error("low latched flags not cleared by read");
  a_latch_high_clears : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rd_i && addr_i == 8'h08 && button_on_flag_i[9:8] == 2'h0 |=> latched[9:8] == 2'h0)
    else $error("high latched flags not cleared by read");

  // ************************************************************
  // cover points
  // ************************************************************
  c_mode_change : cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(device_mode_o));
  c_sleep_cycle : cover property (@(posedge clk_i) disable iff (!rst_n_i)
    deep_sleep_req_o ##[1:20] !deep_sleep_req_o);
  c_soft_reset : cover property (@(posedge clk_i) disable iff (!rst_n_i) soft_reset_o);
  c_latched_read : cover property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rd_i && addr_i == 8'h07 ##1 rdata_o != 8'h00);
endmodule

//--- verif/tb_touch_ctrl_operating_regs.sv
// self-checking bench for the touch controller operating register bank
module tb_touch_ctrl_operating_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i   = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       en, wr, rd, ds_req, soft_rst;
  logic [7:0] addr, wdata, rdata, got, d;
  logic       factory = 1'b0;
  logic       ds_exit = 1'b0;
  logic [9:0] buttons = 10'h000;
  logic [2:0] mode, exp_mode;
  logic [3:0] outs;
  logic [7:0] regs [7] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08};
  logic [7:0] rsv  [5] = '{8'h02, 8'h06, 8'h0A, 8'h19, 8'hFF};
  int         num_errors  = 0;
  int         check_count = 0;
  always #5 clk_i = ~clk_i;
  tcr_host_model i_host (.clk_i(clk_i), .rdata_i(rdata), .en_o(en), .addr_o(addr), .wr_o(wr),
    .wdata_o(wdata), .rd_o(rd));
  tcr_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en), .addr_i(addr), .wr_i(wr),
    .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata), .factory_loaded_i(factory),
    .deep_sleep_exit_i(ds_exit), .button_on_flag_i(buttons), .deep_sleep_req_o(ds_req),
    .soft_reset_o(soft_rst), .device_mode_o(mode), .host_driven_output_o(outs));
  function automatic logic [7:0] exp_status(input logic f);
    return {1'b0, f, 6'h00};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    i_host.read(a, got);
    chk(got, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    d = 8'($urandom(32'h4D583CC8));
    factory = d[0];
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk({ds_req, soft_rst, mode, 3'h0}, 8'h00);
    chk({4'h0, outs}, 8'h00);
    foreach (regs[i]) rdchk(regs[i], (regs[i] == 8'h03) ? exp_status(factory) : 8'h00);
    foreach (rsv[i]) i_host.write(rsv[i], 8'hFF);
    foreach (rsv[i]) rdchk(rsv[i], 8'h00);
    repeat (20) begin
      d = 8'($urandom());
      factory <= d[7];
      buttons <= 10'($urandom());
      i_host.write(8'h01, d);
      chk({4'h0, outs}, {4'h0, d[7:4]});
      rdchk(8'h01, {d[7:4], 4'h0});
      i_host.write(8'h03 + 8'(d[1:0]), ~d);
      rdchk(8'h03, exp_status(factory));
      rdchk(8'h04, buttons[7:0]);
      rdchk(8'h05, {6'h00, buttons[9:8]});
    end
    i_host.frozen_write(8'h01, ~d);
    chk({4'h0, outs}, {4'h0, d[7:4]});
    exp_mode = 3'h0;
    for (int m = 0; m < 8; m++) begin
      i_host.write(8'h00, {3'h7, 2'h0, 3'(m)});
      if (m <= 4) exp_mode = 3'(m);
      chk({5'h00, mode}, {5'h00, exp_mode});
      chk({7'h00, soft_rst}, 8'h00);
      rdchk(8'h00, {5'h00, exp_mode});
    end
    i_host.write(8'h00, 8'h0C);
    chk({7'h00, soft_rst}, 8'h01);
    @(posedge clk_i);
    #1;
    chk({7'h00, soft_rst}, 8'h00);
    ds_exit <= 1'b1;
    i_host.write(8'h00, 8'h10);
    ds_exit <= 1'b0;
    chk({7'h00, ds_req}, 8'h01);
    rdchk(8'h00, 8'h10);
    @(posedge clk_i);
    ds_exit <= 1'b1;
    @(posedge clk_i);
    ds_exit <= 1'b0;
    #1;
    chk({7'h00, ds_req}, 8'h00);
    buttons <= 10'h000;
    i_host.read(8'h07, got);
    i_host.read(8'h08, got);
    @(posedge clk_i);
    buttons <= 10'h201;
    @(posedge clk_i);
    buttons <= 10'h000;
    rdchk(8'h07, 8'h01);
    rdchk(8'h08, 8'h02);
    rdchk(8'h07, 8'h00);
    i_host.write(8'h01, 8'hA0);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk({ds_req, mode, outs}, 8'h00);
    rdchk(8'h01, 8'h00);
    report_and_stop();
  end
endmodule

//--- verif/tcr_host_model.sv
// host model driving the strobes of the touch register bank
module tcr_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            en_o,
  output logic [7:0]      addr_o,
  output logic            wr_o,
  output logic [7:0]      wdata_o,
  output logic            rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    en_o    = 1'b1;
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
    rd_o    = 1'b0;
  end
  // one byte per write, strobe high for exactly one edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d; // idle bus never shows the stale byte
    #1;
  endtask
  // read data is registered, so it is taken one cycle after the strobe
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
  // a write offered while the clock enable is low must leave no trace
  task automatic frozen_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    en_o    <= 1'b0;
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    en_o    <= 1'b1;
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
    #1;
  endtask
endmodule
